// file: srg_pkg.sv
// Constants, register map and field layout of the serial rate generator.
// Assumes one 200 MHz ref_clk domain and an AHB-Lite master with 32-bit data.
package srg_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE1 = 8'h00;
  localparam logic [7:0] ADDR_MODE2 = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] REG_RST = 8'h00;
  // ---------------------------------------------------------------
  // Fields
  // ---------------------------------------------------------------
  localparam int M1_MULT_LSB = 0;
  localparam int M2_RATE_LSB = 0;
  localparam int M2_RXINT_BIT = 4;
  localparam int M2_TXINT_BIT = 5;
  localparam int M2_RXBRK_BIT = 6;
  localparam int CMD_TXEN_BIT = 0;
  localparam int CMD_RXEN_BIT = 2;
  localparam int ST_RUN_BIT = 0;
  localparam int ST_TXSEEN_BIT = 1;
  localparam int ST_RXSEEN_BIT = 2;
  localparam int ST_BRK_BIT = 3;
  localparam int ST_RXPIN_BIT = 4;
  localparam logic [7:0] ST_W1C_MASK = 8'h06;
  // ---------------------------------------------------------------
  // Clock modes and counts
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SRG_SYNC_1X = 2'b00,
    SRG_ASYNC_1X = 2'b01,
    SRG_ASYNC_16X = 2'b10,
    SRG_ASYNC_64X = 2'b11
  } srg_mult_t;
  typedef enum logic [0:0] {
    SRG_IDLE = 1'b0,
    SRG_RUN = 1'b1
  } srg_gen_t;
  localparam int DIV_W = 13;
  localparam int MCNT_W = 6;
  localparam logic [MCNT_W-1:0] MCNT_1X = 6'h00;
  localparam logic [MCNT_W-1:0] MCNT_16X = 6'h0F;
  localparam logic [MCNT_W-1:0] MCNT_64X = 6'h3F;
  localparam int SYNC_STAGES = 3;
endpackage : srg_pkg

// file: srg_top.sv
// Rate divider unit, clock steering and master reset with AHB-Lite registers.
// Assumes rate_source_clock and both bit clock pins are slow against ref_clk.
`timescale 1ns/1ps
module srg_top
  import srg_pkg::*;
#(
  parameter int RATE_SET = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic master_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rate_source_clock,
  input wire logic tx_clk_in,
  output logic tx_clk_out,
  output logic tx_clk_oe,
  input wire logic rx_clk_in,
  output logic rx_clk_out,
  output logic rx_clk_oe,
  input wire logic line_break_flag,
  output logic tx_bit_tick,
  output logic rx_bit_tick,
  output logic rx_sample_tick
);

  initial begin
    if (RATE_SET < 1 || RATE_SET > 3) begin
      $error("RATE_SET must be 1, 2 or 3");
    end
  end

  // ---------------------------------------------------------------
  // Rate tables
  // ---------------------------------------------------------------
  function automatic logic [DIV_W-1:0] rate_div(input logic [3:0] code);
    logic [DIV_W-1:0] d;
    d = 13'h0010;
    if (RATE_SET == 1) begin
      case (code)
        4'h0: d = 13'd6144;
        4'h1: d = 13'd4096;
        4'h2: d = 13'd2793;
        4'h3: d = 13'd2284;
        4'h4: d = 13'd2048;
        4'h5: d = 13'd1536;
        4'h6: d = 13'd1024;
        4'h7: d = 13'd512;
        4'h8: d = 13'd292;
        4'h9: d = 13'd256;
        4'hA: d = 13'd171;
        4'hB: d = 13'd154;
        4'hC: d = 13'd128;
        4'hD: d = 13'd64;
        4'hE: d = 13'd32;
        default: d = 13'd16;
      endcase
    end else if (RATE_SET == 2) begin
      case (code)
        4'h0: d = 13'd6752;
        4'h1: d = 13'd6144;
        4'h2: d = 13'd4096;
        4'h3: d = 13'd2793;
        4'h4: d = 13'd2284;
        4'h5: d = 13'd2048;
        4'h6: d = 13'd1024;
        4'h7: d = 13'd512;
        4'h8: d = 13'd256;
        4'h9: d = 13'd171;
        4'hA: d = 13'd154;
        4'hB: d = 13'd128;
        4'hC: d = 13'd64;
        4'hD: d = 13'd32;
        4'hE: d = 13'd16;
        default: d = 13'd8;
      endcase
    end else begin
      case (code)
        4'h0: d = 13'd6336;
        4'h1: d = 13'd4224;
        4'h2: d = 13'd2880;
        4'h3: d = 13'd2355;
        4'h4: d = 13'd2112;
        4'h5: d = 13'd1056;
        4'h6: d = 13'd528;
        4'h7: d = 13'd264;
        4'h8: d = 13'd176;
        4'h9: d = 13'd158;
        4'hA: d = 13'd132;
        4'hB: d = 13'd88;
        4'hC: d = 13'd66;
        4'hD: d = 13'd44;
        4'hE: d = 13'd33;
        default: d = 13'd16;
      endcase
    end
    return d;
  endfunction

  // Terminal count of the bit-rate prescaler for a clock mode
  function automatic logic [MCNT_W-1:0] mult_last(input logic [1:0] m);
    logic [MCNT_W-1:0] r;
    r = MCNT_1X;
    case (m)
      SRG_ASYNC_16X: r = MCNT_16X;
      SRG_ASYNC_64X: r = MCNT_64X;
      default: r = MCNT_1X;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] mode1_ff;
  logic [7:0] mode2_ff;
  logic [7:0] cmd_ff;
  logic [7:0] stat_ff;
  logic [7:0] nxt_stat;
  logic wr_pend_ff;
  logic [7:0] waddr_ff;
  logic [31:0] hrdata_ff;
  logic addr_ok;
  logic [7:0] rd_val;
  logic [7:0] wdat;
  logic [1:0] mult;
  logic tx_int;
  logic rx_int;

  assign mult = mode1_ff[M1_MULT_LSB +: 2];
  assign tx_int = mode2_ff[M2_TXINT_BIT];
  // A synchronous receiver never runs from the divider
  assign rx_int = mode2_ff[M2_RXINT_BIT] && (mult != SRG_SYNC_1X);
  assign addr_ok = hsel && htrans[1] && hready;
  assign wdat = hwdata[7:0];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      wr_pend_ff <= 1'b0;
      waddr_ff <= REG_RST;
    end else if (!rstn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff <= REG_RST;
    end else begin
      wr_pend_ff <= addr_ok && hwrite;
      if (addr_ok) begin
        waddr_ff <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      mode1_ff <= REG_RST;
      mode2_ff <= REG_RST;
      cmd_ff <= REG_RST;
    end else if (!rstn) begin
      mode1_ff <= REG_RST;
      mode2_ff <= REG_RST;
      cmd_ff <= REG_RST;
    end else if (wr_pend_ff) begin
      if (waddr_ff == ADDR_MODE1) begin
        mode1_ff <= wdat;
      end
      if (waddr_ff == ADDR_MODE2) begin
        mode2_ff <= wdat;
      end
      if (waddr_ff == ADDR_CMD) begin
        cmd_ff <= wdat;
      end
    end
  end

  // Read mux; a write still in its data phase is forwarded unless it targets ADDR_STAT
  always_comb begin
    rd_val = 8'h00;
    case (haddr[7:0])
      ADDR_MODE1: rd_val = mode1_ff;
      ADDR_MODE2: rd_val = mode2_ff;
      ADDR_CMD: rd_val = cmd_ff;
      ADDR_STAT: rd_val = stat_ff;
      default: rd_val = 8'h00;
    endcase
    if (wr_pend_ff && waddr_ff == haddr[7:0] && waddr_ff != ADDR_STAT) begin
      rd_val = wdat;
    end
  end

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (!rstn) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata_ff <= {24'h00_0000, rd_val};
    end
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_STAGES-1:0] src_s_ff;
  logic [SYNC_STAGES-1:0] txc_s_ff;
  logic [SYNC_STAGES-1:0] rxc_s_ff;
  logic [1:0] brk_s_ff;
  logic src_rise;
  logic tx_ext_fall;
  logic rx_ext_rise;

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      src_s_ff <= '0;
      txc_s_ff <= '0;
      rxc_s_ff <= '0;
      brk_s_ff <= 2'h0;
    end else if (!rstn) begin
      src_s_ff <= '0;
      txc_s_ff <= '0;
      rxc_s_ff <= '0;
      brk_s_ff <= 2'h0;
    end else begin
      src_s_ff <= {src_s_ff[SYNC_STAGES-2:0], rate_source_clock};
      txc_s_ff <= {txc_s_ff[SYNC_STAGES-2:0], tx_clk_in};
      rxc_s_ff <= {rxc_s_ff[SYNC_STAGES-2:0], rx_clk_in};
      brk_s_ff <= {brk_s_ff[0], line_break_flag};
    end
  end

  // Edges come from stages two and three only
  assign src_rise = src_s_ff[1] && !src_s_ff[2];
  assign tx_ext_fall = !txc_s_ff[1] && txc_s_ff[2];
  assign rx_ext_rise = rxc_s_ff[1] && !rxc_s_ff[2];

  // ---------------------------------------------------------------
  // Rate divider unit
  // ---------------------------------------------------------------
  srg_gen_t gen_ff;
  srg_gen_t nxt_gen;
  logic [DIV_W-1:0] div_cnt_ff;
  logic [DIV_W-1:0] divisor;
  logic gen_tick_ff;
  logic clk16_ff;
  logic want_gen;

  assign divisor = rate_div(mode2_ff[M2_RATE_LSB +: 4]);
  assign want_gen = (cmd_ff[CMD_TXEN_BIT] && tx_int) || (cmd_ff[CMD_RXEN_BIT] && rx_int);

  always_comb begin
    nxt_gen = gen_ff;
    case (gen_ff)
      SRG_IDLE: if (want_gen) nxt_gen = SRG_RUN;
      SRG_RUN: if (!want_gen) nxt_gen = SRG_IDLE;
      default: nxt_gen = SRG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      gen_ff <= SRG_IDLE;
    end else if (!rstn) begin
      gen_ff <= SRG_IDLE;
    end else begin
      gen_ff <= nxt_gen;
    end
  end

  // Output is high for the first half of each divisor span
  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      div_cnt_ff <= '0;
      gen_tick_ff <= 1'b0;
      clk16_ff <= 1'b0;
    end else if (!rstn) begin
      div_cnt_ff <= '0;
      gen_tick_ff <= 1'b0;
      clk16_ff <= 1'b0;
    end else if (gen_ff != SRG_RUN) begin
      div_cnt_ff <= '0;
      gen_tick_ff <= 1'b0;
      clk16_ff <= 1'b0;
    end else begin
      gen_tick_ff <= 1'b0;
      if (src_rise) begin
        if (div_cnt_ff == '0) begin
          div_cnt_ff <= divisor - 13'd1;
          gen_tick_ff <= 1'b1;
          clk16_ff <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff - 13'd1;
          if (div_cnt_ff <= {1'b0, divisor[DIV_W-1:1]}) begin
            clk16_ff <= 1'b0;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Bit clock steering and prescalers
  // ---------------------------------------------------------------
  logic tx_base;
  logic rx_base;
  logic [MCNT_W-1:0] tx_pre_ff;
  logic [MCNT_W-1:0] rx_pre_ff;
  logic tx_bit_ff;
  logic rx_bit_ff;
  logic rx_samp_ff;
  logic tx_pin_ff;
  logic rx_pin_ff;

  // Divider output is the 16X or 64X clock in async 16X/64X, the bit clock in sync and async 1X
  assign tx_base = tx_int ? gen_tick_ff : tx_ext_fall;
  assign rx_base = rx_int ? gen_tick_ff : rx_ext_rise;
  // Ceiling on bit rate is set by the pin sampling, far above 1M bps
  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      tx_pre_ff <= '0;
      tx_bit_ff <= 1'b0;
    end else if (!rstn || !cmd_ff[CMD_TXEN_BIT]) begin
      tx_pre_ff <= '0;
      tx_bit_ff <= 1'b0;
    end else begin
      tx_bit_ff <= 1'b0;
      if (tx_base) begin
        if (tx_pre_ff >= mult_last(mult)) begin
          tx_pre_ff <= '0;
          tx_bit_ff <= 1'b1;
        end else begin
          tx_pre_ff <= tx_pre_ff + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      rx_pre_ff <= '0;
      rx_bit_ff <= 1'b0;
      rx_samp_ff <= 1'b0;
    end else if (!rstn || !cmd_ff[CMD_RXEN_BIT]) begin
      rx_pre_ff <= '0;
      rx_bit_ff <= 1'b0;
      rx_samp_ff <= 1'b0;
    end else begin
      rx_bit_ff <= 1'b0;
      rx_samp_ff <= rx_base;
      if (rx_base) begin
        if (rx_pre_ff >= mult_last(mult)) begin
          rx_pre_ff <= '0;
          rx_bit_ff <= 1'b1;
        end else begin
          rx_pre_ff <= rx_pre_ff + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      tx_pin_ff <= 1'b0;
      rx_pin_ff <= 1'b0;
    end else if (!rstn) begin
      tx_pin_ff <= 1'b0;
      rx_pin_ff <= 1'b0;
    end else begin
      tx_pin_ff <= clk16_ff;
      rx_pin_ff <= mode2_ff[M2_RXBRK_BIT] ? brk_s_ff[1] : clk16_ff;
    end
  end

  assign tx_clk_out = tx_pin_ff;
  assign tx_clk_oe = tx_int;
  assign rx_clk_out = rx_pin_ff;
  assign rx_clk_oe = rx_int;
  assign tx_bit_tick = tx_bit_ff;
  assign rx_bit_tick = rx_bit_ff;
  assign rx_sample_tick = rx_samp_ff;

  // ---------------------------------------------------------------
  // Status
  // ---------------------------------------------------------------
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_pend_ff && waddr_ff == ADDR_STAT) begin
      nxt_stat = stat_ff & ~(wdat & ST_W1C_MASK);
    end
    // Setting beats a clear in the same cycle
    if (tx_bit_ff) nxt_stat[ST_TXSEEN_BIT] = 1'b1;
    if (rx_bit_ff) nxt_stat[ST_RXSEEN_BIT] = 1'b1;
    nxt_stat[ST_RUN_BIT] = (gen_ff == SRG_RUN);
    nxt_stat[ST_BRK_BIT] = brk_s_ff[1];
    nxt_stat[ST_RXPIN_BIT] = rx_int;
  end

  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      stat_ff <= REG_RST;
    end else if (!rstn) begin
      stat_ff <= REG_RST;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

endmodule // srg_top

// file: srg_top_checker.sv
// Concurrent checks on the ports of the serial rate generator top.
// Assumes one ref_clk domain; bus writes are shadowed to know the mode.
`timescale 1ns/1ps
module srg_top_checker
  import srg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic master_reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic line_break_flag,
  input wire logic tx_clk_oe,
  input wire logic rx_clk_out,
  input wire logic rx_clk_oe,
  input wire logic tx_bit_tick,
  input wire logic rx_bit_tick,
  input wire logic rx_sample_tick
);
  // ---------------------------------------------------------------
  // Shadow of the mode and command writes
  // ---------------------------------------------------------------
  logic wr_ph_ff;
  logic [7:0] wa_ff;
  logic [1:0] m1_ff;
  logic [7:0] m2_ff;
  logic [7:0] cmd_ff;
  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset) begin
      wr_ph_ff <= 1'b0;
      wa_ff <= 8'h00;
    end else begin
      wr_ph_ff <= rstn && hsel && htrans[1] && hready && hwrite;
      wa_ff <= haddr[7:0];
    end
  end
  always_ff @(posedge ref_clk or posedge master_reset) begin
    if (master_reset || !rstn) begin
      m1_ff <= 2'h0;
      m2_ff <= 8'h00;
      cmd_ff <= 8'h00;
    end else if (wr_ph_ff) begin
      if (wa_ff == ADDR_MODE1) m1_ff <= hwdata[1:0];
      if (wa_ff == ADDR_MODE2) m2_ff <= hwdata[7:0];
      if (wa_ff == ADDR_CMD) cmd_ff <= hwdata[7:0];
    end
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn || master_reset);
  // A tick still in flight may leave one cycle after disable
  sequence tx_off; (!cmd_ff[CMD_TXEN_BIT])[*3]; endsequence
  sequence rx_off; (!cmd_ff[CMD_RXEN_BIT])[*3]; endsequence
  sequence brk_on; (line_break_flag && m2_ff[6] && rx_clk_oe)[*6]; endsequence
  sequence brk_off; (!line_break_flag && m2_ff[6] && rx_clk_oe)[*6]; endsequence
  a_mreset_clear: assert property (disable iff (!rstn) master_reset |->
    (!tx_bit_tick && !rx_bit_tick && !tx_clk_oe && !rx_clk_oe && hrdata == 32'h0))
    else $error("outputs not cleared during master reset");
  a_rstn_clear: assert property (disable iff (master_reset) !rstn |=>
    (!tx_bit_tick && !rx_sample_tick && !tx_clk_oe && hrdata == 32'h0))
    else $error("outputs not cleared after reset");
  a_tx_oe_mode: assert property ($stable(m2_ff[5]) |-> tx_clk_oe == m2_ff[5])
    else $error("transmit pin enable does not follow mode");
  a_rx_oe_mode: assert property ($stable(m2_ff[4]) && $stable(m1_ff) |->
    rx_clk_oe == (m2_ff[4] && m1_ff != 2'h0))
    else $error("receive pin enable wrong for mode");
  a_tx_idle: assert property (tx_off |-> !tx_bit_tick)
    else $error("transmit tick while disabled");
  a_rx_idle: assert property (rx_off |-> !rx_bit_tick && !rx_sample_tick)
    else $error("receive tick while disabled");
  a_tick_pulse: assert property (tx_bit_tick |=> !tx_bit_tick)
    else $error("transmit tick longer than one cycle");
  a_sample_pulse: assert property (rx_sample_tick |=> !rx_sample_tick)
    else $error("sample tick longer than one cycle");
  a_break_high: assert property (brk_on |-> rx_clk_out)
    else $error("receive pin does not show break");
  a_break_low: assert property (brk_off |-> !rx_clk_out)
    else $error("receive pin shows break without flag");
endmodule // srg_top_checker

// file: srg_partner.sv
// Far side of the rate generator: source crystal and external clock pins.
// Assumes ref_clk rising edges at 2.5 ns plus multiples of 5 ns.
`timescale 1ns/1ps
module srg_partner (
  output logic rate_source_clock,
  output logic tx_clk_in,
  output logic rx_clk_in,
  output logic line_break_flag,
  input wire logic tx_clk_out,
  input wire logic tx_clk_oe,
  input wire logic rx_clk_out,
  input wire logic rx_clk_oe
);
  // ---------------------------------------------------------------
  // Crystal and pins
  // ---------------------------------------------------------------
  logic ext_tx = 1'b1;
  logic ext_rx = 1'b1;
  // Edges at multiples of 10 ns never meet a ref_clk rising edge
  initial begin
    rate_source_clock = 1'b0;
    line_break_flag = 1'b0;
    forever #10 rate_source_clock = ~rate_source_clock;
  end
  // The block's drive wins while it enables the pin
  assign tx_clk_in = tx_clk_oe ? tx_clk_out : ext_tx;
  assign rx_clk_in = rx_clk_oe ? rx_clk_out : ext_rx;
  // External transmit clock runs only within a burst and rests high
  task automatic tx_falls(input int n);
    #1;
    repeat (n) begin
      #20 ext_tx = 1'b0;
      #20 ext_tx = 1'b1;
    end
  endtask
endmodule // srg_partner

// file: srg_top_test.sv
// Self-checking bench for srg_top, rate set 1, driven over AHB-Lite.
// Assumes srg_partner supplies the source crystal and external pins.
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module srg_top_test
  import srg_pkg::*;
;
  localparam int SRC_CYC = 4;
  localparam int LIMIT = 90000;
  logic ref_clk, rstn, master_reset, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire [31:0] hrdata;
  wire hreadyout, hresp, rate_source_clock, tx_clk_in, rx_clk_in, line_break_flag;
  wire tx_clk_out, tx_clk_oe, rx_clk_out, rx_clk_oe;
  wire tx_bit_tick, rx_bit_tick, rx_sample_tick;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  srg_top #(.RATE_SET(1)) i_srg_top (.ref_clk, .rstn, .master_reset, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .rate_source_clock, .tx_clk_in, .tx_clk_out, .tx_clk_oe, .rx_clk_in, .rx_clk_out,
    .rx_clk_oe, .line_break_flag, .tx_bit_tick, .rx_bit_tick, .rx_sample_tick);
  srg_partner i_partner (.rate_source_clock, .tx_clk_in, .rx_clk_in, .line_break_flag,
    .tx_clk_out, .tx_clk_oe, .rx_clk_out, .rx_clk_oe);
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, cycles, 0);
      final_report();
    end
  end
  // ---------------------------------------------------------------
  // Bus and sampling tasks
  // ---------------------------------------------------------------
  task automatic final_report;
    $display("Counts: %0d compared, %0d mismatched", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h000000, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask
  function automatic logic tk(input int s);
    return (s == 0) ? tx_bit_tick : (s == 1) ? rx_bit_tick : rx_sample_tick;
  endfunction
  task automatic gap(input int s, output int n);
    n = 0;
    do cyc(); while (tk(s) !== 1'b1);
    do begin
      cyc();
      n++;
    end while (tk(s) !== 1'b1);
  endtask
  task automatic count(input int s, input int len, output int c);
    c = 0;
    repeat (len) begin
      cyc();
      if (tk(s) === 1'b1) c++;
    end
  endtask
  task automatic t_zero;
    logic [31:0] q;
    logic [7:0] regs [4];
    regs = '{ADDR_MODE1, ADDR_MODE2, ADDR_CMD, ADDR_STAT};
    for (int i = 0; i < 4; i++) begin
      rd(regs[i], q);
      `CHK(q, 32'h0)
    end
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    t_zero();
    wr(ADDR_MODE2, 8'h2F);
    rd(ADDR_MODE2, q);
    `CHK(q, 32'h2F)
    wr(8'h10, 8'h55);
    rd(8'h10, q);
    `CHK(q, 32'h0)
    wr(ADDR_MODE2, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_rate(input logic [1:0] m, input logic [3:0] code, input int exp);
    int n;
    wr(ADDR_MODE1, {6'h00, m});
    wr(ADDR_MODE2, {4'h2, code});
    wr(ADDR_CMD, 8'h01);
    gap(0, n);
    `CHK(n, exp)
    wr(ADDR_CMD, 8'h00);
    $display("t_rate done");
  endtask
  task automatic t_rx;
    int n;
    wr(ADDR_MODE1, 8'h02);
    wr(ADDR_MODE2, 8'h1F);
    wr(ADDR_CMD, 8'h04);
    gap(1, n);
    `CHK(n, 16 * 16 * SRC_CYC)
    gap(2, n);
    `CHK(n, 16 * SRC_CYC)
    `CHK(rx_clk_oe, 1'b1)
    wr(ADDR_CMD, 8'h00);
    wr(ADDR_MODE1, 8'h00);
    wr(ADDR_CMD, 8'h04);
    count(1, 300, n);
    `CHK(n, 0)
    `CHK(rx_clk_oe, 1'b0)
    wr(ADDR_CMD, 8'h00);
    $display("t_rx done");
  endtask
  task automatic t_ext(input logic [1:0] m, input int falls, input int exp);
    int n;
    wr(ADDR_MODE1, {6'h00, m});
    wr(ADDR_MODE2, 8'h00);
    wr(ADDR_CMD, 8'h01);
    `CHK(tx_clk_oe, 1'b0)
    fork
      i_partner.tx_falls(falls);
      count(0, falls * 8 + 40, n);
    join
    `CHK(n, exp)
    wr(ADDR_CMD, 8'h00);
    $display("t_ext done");
  endtask
  task automatic t_break;
    logic [31:0] q;
    wr(ADDR_MODE1, 8'h02);
    wr(ADDR_MODE2, 8'h50);
    i_partner.line_break_flag <= 1'b1;
    repeat (8) cyc();
    `CHK(rx_clk_out, 1'b1)
    rd(ADDR_STAT, q);
    `CHK(q[ST_BRK_BIT], 1'b1)
    i_partner.line_break_flag <= 1'b0;
    repeat (8) cyc();
    `CHK(rx_clk_out, 1'b0)
    $display("t_break done");
  endtask
  task automatic t_mreset;
    int n;
    wr(ADDR_MODE1, 8'h02);
    wr(ADDR_MODE2, 8'h3F);
    wr(ADDR_CMD, 8'h05);
    repeat (3) cyc();
    #1 master_reset = 1'b1;
    #1;
    `CHK(tx_clk_oe, 1'b0)
    `CHK(rx_clk_oe, 1'b0)
    repeat (2) @(posedge ref_clk);
    master_reset <= 1'b0;
    t_zero();
    count(0, 200, n);
    `CHK(n, 0)
    $display("t_mreset done");
  endtask
  initial begin
    rstn = 1'b0;
    master_reset = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    t_regs();
    t_rate(SRG_ASYNC_16X, 4'hF, 16 * 16 * SRC_CYC);
    t_rate(SRG_SYNC_1X, 4'hF, 16 * SRC_CYC);
    t_rate(SRG_ASYNC_64X, 4'hF, 16 * 64 * SRC_CYC);
    t_rate(SRG_ASYNC_1X, 4'h7, 512 * SRC_CYC);
    t_rate(SRG_SYNC_1X, 4'h0, 6144 * SRC_CYC);
    t_rx();
    t_ext(SRG_ASYNC_1X, 6, 6);
    t_ext(SRG_ASYNC_16X, 32, 2);
    t_ext(SRG_ASYNC_64X, 64, 1);
    t_break();
    t_mreset();
    final_report();
  end
endmodule // srg_top_test
bind srg_top srg_top_checker i_srg_top_checker (.ref_clk, .rstn, .master_reset, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata, .line_break_flag, .tx_clk_oe,
  .rx_clk_out, .rx_clk_oe, .tx_bit_tick, .rx_bit_tick, .rx_sample_tick);
